/* shared/ppc_pkg.sv */
/*
 * Constants, dictionary indices and carrier types of the positioning
 * parameter block. Assumes a 250 MHz device clock and user units that
 * follow from the scaling numerator and denominator.
 */
package ppc_pkg;

	// Dictionary indices
	localparam logic [15:0] IDX_SCRATCH   = 16'h2000;
	localparam logic [15:0] IDX_GOAL      = 16'h2001;
	localparam logic [15:0] IDX_ACTUAL    = 16'h2003;
	localparam logic [15:0] IDX_OFFSET    = 16'h2004;
	localparam logic [15:0] IDX_FERR      = 16'h2005;
	localparam logic [15:0] IDX_WINDOW    = 16'h2006;
	localparam logic [15:0] IDX_NUM       = 16'h2010;
	localparam logic [15:0] IDX_DEN       = 16'h2011;
	localparam logic [15:0] IDX_SPD_AUTO  = 16'h2012;
	localparam logic [15:0] IDX_SPD_JOG   = 16'h2013;
	localparam logic [15:0] IDX_TRQ_RUN   = 16'h2014;
	localparam logic [15:0] IDX_LIM_HIGH  = 16'h2016;
	localparam logic [15:0] IDX_LIM_LOW   = 16'h2017;
	localparam logic [15:0] IDX_TRQ_START = 16'h2018;
	localparam logic [15:0] IDX_START_MS  = 16'h2019;
	localparam logic [15:0] IDX_MAP_END   = 16'h2028;

	// Scratch store geometry
	localparam logic [7:0]  SCRATCH_COUNT = 8'h0a;
	localparam int          SCRATCH_AW    = 4;

	// Reset values
	localparam logic [15:0] RST_FERR      = 16'h0000;
	localparam logic [15:0] RST_WINDOW    = 16'h0002;
	localparam logic [15:0] RST_SCALE     = 16'h0190;
	localparam logic [15:0] RST_SPD_AUTO  = 16'h0064;
	localparam logic [15:0] RST_SPD_JOG   = 16'h0032;
	localparam logic [15:0] RST_TRQ_RUN   = 16'h0064;
	localparam logic [15:0] RST_TRQ_START = 16'h0096;
	localparam logic [15:0] RST_START_MS  = 16'h00c8;
	localparam logic [31:0] RST_LIM_HIGH  = 32'h00018b50;
	localparam logic [31:0] RST_LIM_LOW   = 32'h000004b0;
	localparam logic [31:0] RST_MAP_END   = 32'h00019000;

	// Accepted value ranges
	localparam logic [15:0] WINDOW_MIN    = 16'h0001;
	localparam logic [31:0] WINDOW_BASE   = 32'h00000064;
	localparam logic [15:0] SCALE_MIN     = 16'h0001;
	localparam logic [15:0] SCALE_MAX     = 16'h2710;
	localparam logic [15:0] FERR_MAX      = 16'h03e8;
	localparam logic [15:0] INC_PER_REV   = 16'h0190;
	localparam logic [31:0] LIM_REV_FAR   = 32'h000000fd;
	localparam logic [31:0] LIM_REV_NEAR  = 32'h00000003;

	// Status word bit positions
	localparam int ST_REACHED    = 0;
	localparam int ST_DRAG       = 1;
	localparam int ST_BAD_TARGET = 12;
	localparam int ST_POS_LIMIT  = 14;
	localparam int ST_NEG_LIMIT  = 15;

	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} ppc_req_t;

	typedef struct packed {
		logic        ack;
		logic        refused;
		logic [31:0] rdata;
	} ppc_rsp_t;

endpackage

/* verification/ppc_motion_model.sv */
/*
 * Stand-in for the motion core: a move lasts MOVE_CYC cycles after a start.
 * Assumes the bench sets position and following error directly.
 */
`timescale 1ns/10ps
module ppc_motion_model #(
	parameter int MOVE_CYC = 60
) (
	input wire logic                sys_clk,
	input wire logic                reset_n,
	input wire logic                go,
	input wire logic                jog_req,
	input wire logic signed [31:0]  pos_set,
	input wire logic signed [31:0]  ferr_set,
	output logic signed [31:0]      raw_position,
	output logic signed [31:0]      follow_error,
	output logic                    axis_moving,
	output logic                    jog_active,
	output logic                    move_start
);
	int cnt;

	// Falling edge keeps changes clear of the design's sampling edge
	always @(negedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			move_start <= 1'b0;
			jog_active <= 1'b0;
		end else begin
			move_start <= (go && !axis_moving) || (jog_req && !jog_active);
			jog_active <= jog_req;
			if (go)
				cnt <= MOVE_CYC;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
	assign axis_moving = (cnt != 0) || jog_active;
	assign raw_position = pos_set;
	assign follow_error = ferr_set;
endmodule

/* verification/ppc_param_ctrl_asserts.sv */
/*
 * Port-level assertions for the positioning parameter block.
 * Assumes it is bound to ppc_param_ctrl, one clock, async low reset.
 */
`timescale 1ns/10ps
module ppc_param_ctrl_asserts #(
	parameter int CYC_PER_MS = 10
) (
	input wire logic                sys_clk,
	input wire logic                reset_n,
	input wire logic                req_valid,
	input wire ppc_pkg::ppc_req_t   req,
	input wire ppc_pkg::ppc_rsp_t   rsp_r,
	input wire logic signed [31:0]  raw_position,
	input wire logic signed [31:0]  follow_error,
	input wire logic                axis_moving,
	input wire logic                jog_active,
	input wire logic                move_start,
	input wire logic signed [31:0]  drive_target_r,
	input wire logic                target_go_r,
	input wire logic [15:0]         speed_limit_r,
	input wire logic [15:0]         torque_limit_r,
	input wire logic [15:0]         status_word_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	wire wr_req = req_valid && req.wr;
	wire goal_wr = wr_req && (req.index == ppc_pkg::IDX_GOAL) && (req.sub == 8'h00);
	wire win_wr = wr_req && (req.index == ppc_pkg::IDX_WINDOW);
	wire cnt_wr = wr_req && (req.index == ppc_pkg::IDX_SCRATCH) && (req.sub == 8'h00);

	property p_ack_lat; req_valid |-> ##2 rsp_r.ack; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_no_stray; rsp_r.ack |-> $past(req_valid, 2); endproperty
	a_no_stray: assert property (p_no_stray) else $error("ack without request");
	property p_cnt_ro; cnt_wr |-> ##2 (rsp_r.ack && rsp_r.refused); endproperty
	a_cnt_ro: assert property (p_cnt_ro) else $error("count entry written");
	property p_gated; win_wr ##1 axis_moving |=> (rsp_r.ack && rsp_r.refused); endproperty
	a_gated: assert property (p_gated) else $error("write taken while moving");
	property p_go_goal; target_go_r |-> (rsp_r.ack && !rsp_r.refused && $past(goal_wr, 2)); endproperty
	a_go_goal: assert property (p_go_goal) else $error("start without goal write");
	property p_bad_tgt; (rsp_r.refused && $past(goal_wr, 2)) |-> (status_word_r[12] && !target_go_r); endproperty
	a_bad_tgt: assert property (p_bad_tgt) else $error("bad goal not flagged");
	property p_drag; status_word_r[1] |-> $past(axis_moving); endproperty
	a_drag: assert property (p_drag) else $error("drag flag at standstill");
	property p_reached; status_word_r[0] |-> !$past(axis_moving); endproperty
	a_reached: assert property (p_reached) else $error("reached while moving");
	property p_refz; rsp_r.refused |-> (rsp_r.ack && (rsp_r.rdata == 32'h0)); endproperty
	a_refz: assert property (p_refz) else $error("refusal carries data");

	c_go: cover property (target_go_r);
	c_ref: cover property (rsp_r.ack && rsp_r.refused);
	c_drag: cover property (status_word_r[1]);
endmodule

bind ppc_param_ctrl ppc_param_ctrl_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_asserts (
	.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .rsp_r(rsp_r),
	.raw_position(raw_position), .follow_error(follow_error), .axis_moving(axis_moving),
	.jog_active(jog_active), .move_start(move_start), .drive_target_r(drive_target_r),
	.target_go_r(target_go_r), .speed_limit_r(speed_limit_r), .torque_limit_r(torque_limit_r),
	.status_word_r(status_word_r));

/* verification/ppc_param_ctrl_tb.sv */
/*
 * Self-checking bench for ppc_param_ctrl driving dictionary requests.
 * Assumes ppc_motion_model on the motion side, short millisecond count.
 */
`timescale 1ns/10ps
module ppc_param_ctrl_tb;
	logic               sys_clk, reset_n, req_valid, jog_req;
	ppc_pkg::ppc_req_t  req;
	ppc_pkg::ppc_rsp_t  rsp_r;
	logic signed [31:0] raw_position, follow_error, drive_target_r, pos_set, ferr_set;
	logic               axis_moving, jog_active, move_start, target_go_r;
	logic [15:0]        speed_limit_r, torque_limit_r, status_word_r;
	int                 err_count, checks_done;
	localparam logic [15:0] DIX [9] = '{ppc_pkg::IDX_GOAL, ppc_pkg::IDX_OFFSET, ppc_pkg::IDX_FERR,
		ppc_pkg::IDX_WINDOW, ppc_pkg::IDX_NUM, ppc_pkg::IDX_DEN, ppc_pkg::IDX_LIM_HIGH,
		ppc_pkg::IDX_LIM_LOW, ppc_pkg::IDX_START_MS};
	localparam logic [31:0] DEV [9] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h190, 32'h190, 32'h18b50,
		32'h4b0, 32'hc8};

	ppc_param_ctrl #(.CYC_PER_MS(10)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
		.req(req), .rsp_r(rsp_r), .raw_position(raw_position), .follow_error(follow_error),
		.axis_moving(axis_moving), .jog_active(jog_active), .move_start(move_start),
		.drive_target_r(drive_target_r), .target_go_r(target_go_r), .speed_limit_r(speed_limit_r),
		.torque_limit_r(torque_limit_r), .status_word_r(status_word_r));
	ppc_motion_model u_motion (.sys_clk(sys_clk), .reset_n(reset_n), .go(target_go_r), .jog_req(jog_req),
		.pos_set(pos_set), .ferr_set(ferr_set), .raw_position(raw_position), .follow_error(follow_error),
		.axis_moving(axis_moving), .jog_active(jog_active), .move_start(move_start));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Accepted read compares data; write only checks the verdict
	task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
		input logic rf);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = '{w, ix, sb, (w ? d : 32'h0)};
		@(negedge sys_clk);
		req_valid = 1'b0;
		// Answer stands for one cycle only, so look mid-cycle
		@(negedge sys_clk);
		chk(32'(rsp_r.ack), 32'h1);
		chk(32'(rsp_r.refused), 32'(rf));
		if (!w && !rf)
			chk(rsp_r.rdata, d);
	endtask

	task automatic end_sim;
		$display("err_count %0d checks_done %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge sys_clk);
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		jog_req = 1'b0;
		pos_set = 32'sh0;
		ferr_set = 32'sh0;
		err_count = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk) reset_n = 1'b1;
		for (int i = 0; i < 9; i++)
			acc(1'b0, DIX[i], 8'h0, DEV[i], 1'b0);
		acc(1'b0, ppc_pkg::IDX_SCRATCH, 8'h0, 32'ha, 1'b0);
		chk(32'(status_word_r[15]), 32'h1);
		acc(1'b1, ppc_pkg::IDX_SCRATCH, 8'h0, 32'h5, 1'b1);
		acc(1'b1, ppc_pkg::IDX_SCRATCH, 8'h1, 32'hdead0001, 1'b0);
		acc(1'b1, ppc_pkg::IDX_SCRATCH, 8'ha, 32'hbeef000a, 1'b0);
		acc(1'b1, ppc_pkg::IDX_SCRATCH, 8'hb, 32'h1, 1'b1);
		acc(1'b0, ppc_pkg::IDX_SCRATCH, 8'h1, 32'hdead0001, 1'b0);
		acc(1'b0, ppc_pkg::IDX_SCRATCH, 8'ha, 32'hbeef000a, 1'b0);
		acc(1'b0, 16'h2002, 8'h0, 32'h0, 1'b1);
		acc(1'b1, ppc_pkg::IDX_LIM_HIGH, 8'h0, 32'h18b51, 1'b1);
		acc(1'b1, ppc_pkg::IDX_LIM_HIGH, 8'h0, 32'h4af, 1'b1);
		acc(1'b1, ppc_pkg::IDX_LIM_HIGH, 8'h0, 32'h4b0, 1'b0);
		acc(1'b1, ppc_pkg::IDX_LIM_HIGH, 8'h0, 32'h18b50, 1'b0);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h64, 1'b0);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h65, 1'b1);
		acc(1'b1, ppc_pkg::IDX_DEN, 8'h0, 32'h96, 1'b0);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h26, 1'b1);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h25, 1'b0);
		acc(1'b1, ppc_pkg::IDX_NUM, 8'h0, 32'h0, 1'b1);
		acc(1'b1, ppc_pkg::IDX_DEN, 8'h0, 32'h2711, 1'b1);
		acc(1'b1, ppc_pkg::IDX_DEN, 8'h0, 32'h190, 1'b0);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h2, 1'b0);
		acc(1'b1, ppc_pkg::IDX_FERR, 8'h0, 32'ha, 1'b0);
		acc(1'b1, ppc_pkg::IDX_START_MS, 8'h0, 32'h2, 1'b0);
		acc(1'b1, ppc_pkg::IDX_GOAL, 8'h0, 32'h4af, 1'b1);
		chk(32'(status_word_r[12]), 32'h1);
		chk(32'(target_go_r), 32'h0);
		acc(1'b0, ppc_pkg::IDX_GOAL, 8'h0, 32'h0, 1'b0);
		ferr_set = 32'sd11;
		acc(1'b1, ppc_pkg::IDX_GOAL, 8'h0, 32'h7d0, 1'b0);
		chk(32'(target_go_r), 32'h1);
		chk(32'(status_word_r[12]), 32'h0);
		repeat (6) @(posedge sys_clk);
		#1;
		chk(32'(torque_limit_r), 32'h96);
		chk(drive_target_r, 32'h000007d0);
		chk(32'(status_word_r[1]), 32'h1);
		repeat (25) @(posedge sys_clk);
		#1;
		chk(32'(torque_limit_r), 32'h64);
		acc(1'b1, ppc_pkg::IDX_WINDOW, 8'h0, 32'h5, 1'b1);
		acc(1'b0, ppc_pkg::IDX_WINDOW, 8'h0, 32'h2, 1'b0);
		pos_set = 32'sd2002;
		ferr_set = 32'sd0;
		repeat (30) @(posedge sys_clk);
		#1;
		chk(32'(status_word_r[0]), 32'h1);
		chk(32'(status_word_r[1]), 32'h0);
		pos_set = 32'sd2003;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(32'(status_word_r[0]), 32'h0);
		acc(1'b1, ppc_pkg::IDX_ACTUAL, 8'h0, 32'd5000, 1'b0);
		acc(1'b0, ppc_pkg::IDX_ACTUAL, 8'h0, 32'd5000, 1'b0);
		acc(1'b1, ppc_pkg::IDX_OFFSET, 8'h0, 32'd100, 1'b0);
		acc(1'b0, ppc_pkg::IDX_ACTUAL, 8'h0, 32'd5100, 1'b0);
		// Goal 2000 seen from the raw frame, now shifted by 3097
		chk(drive_target_r, 32'hfffffbb7);
		pos_set = 32'sd98103;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(32'(status_word_r[14]), 32'h1);
		chk(32'(status_word_r[15]), 32'h0);
		acc(1'b1, ppc_pkg::IDX_SPD_AUTO, 8'h0, 32'h123, 1'b0);
		acc(1'b1, ppc_pkg::IDX_SPD_JOG, 8'h0, 32'h45, 1'b0);
		chk(32'(speed_limit_r), 32'h123);
		@(negedge sys_clk) jog_req = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk(32'(speed_limit_r), 32'h45);
		@(negedge sys_clk) jog_req = 1'b0;
		end_sim();
	end
endmodule

/* verilog/ppc_param_ctrl.sv */
/*
 * Parameter set and supervision of a spindle positioning drive: dictionary
 * access port, scaling, referencing, travel limits, reached and drag flags,
 * speed and torque limit selection. Assumes a motion core that reports
 * raw position in motor increments, following error in user units and a
 * moving flag, all synchronous to sys_clk.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - Ten retained 32-bit scratch entries, plus read-only count entry reading ten.
// - Signed goal position in user units, reset zero; positioning drives toward it.
// - Writing actual position re-references it to the written value; reads give present position.
// - Referencing, scaling, window, limits and actual writes only accepted at standstill.
// - Retained signed offset, reset zero, corrects goal, actual and limit values.
// - Drag-error flag set while moving when following error exceeds programmable 16-bit maximum.
// - Position-reached at standstill when goal and actual differ by at most window, default 2.
// - Window upper bound scales with the selected user resolution.
// - Increments convert to user units by retained 16-bit ratio, both default 400.
// - Positioning runs limited by programmable 16-bit maximum speed.
// - Manual runs limited by separate programmable 16-bit maximum speed.
// - Start-up torque limit during start phase, running torque limit afterwards.
// - Upper limit accepted between mapping end minus 253 and minus 3 revolutions.
// - Lower limit default 1200; goals below it refused; settable at standstill only.
// - Status bits: reached 0, drag 1, bad target 12, range limits 14, 15.
// - Start phase lasts programmable milliseconds, default 200.
module ppc_param_ctrl #(
	parameter int CYC_PER_MS = ppc_pkg::CYC_PER_MS
) (
	input  wire logic                    sys_clk,
	input  wire logic                    reset_n,
	input  wire logic                    req_valid,
	input  wire ppc_pkg::ppc_req_t       req,
	output ppc_pkg::ppc_rsp_t            rsp_r,
	input  wire logic signed [31:0]      raw_position,
	input  wire logic signed [31:0]      follow_error,
	input  wire logic                    axis_moving,
	input  wire logic                    jog_active,
	input  wire logic                    move_start,
	output logic signed [31:0]           drive_target_r,
	output logic                         target_go_r,
	output logic [15:0]                  speed_limit_r,
	output logic [15:0]                  torque_limit_r,
	output logic [15:0]                  status_word_r
);
	// Parameter registers
	logic signed [31:0] goal_r;
	logic signed [31:0] offset_r;
	logic signed [31:0] home_shift_r;
	logic signed [31:0] lim_high_r;
	logic signed [31:0] lim_low_r;
	logic signed [31:0] map_end_r;
	logic [15:0]        ferr_max_r;
	logic [15:0]        window_r;
	logic [15:0]        num_r;
	logic [15:0]        den_r;
	logic [15:0]        spd_auto_r;
	logic [15:0]        spd_jog_r;
	logic [15:0]        trq_run_r;
	logic [15:0]        trq_start_r;
	logic [15:0]        start_ms_r;
	logic               bad_target_r;

	// Request stage
	logic               q_valid_r;
	ppc_pkg::ppc_req_t  q_r;

	// Start phase timer
	logic               in_start_r;
	logic [31:0]        prescale_r;
	logic [15:0]        ms_cnt_r;

	logic [31:0]        scratch_rdata;

	// Scaling arithmetic
	wire logic signed [48:0] pos_prod   = 49'(raw_position) * $signed({33'h0, den_r});
	wire logic signed [48:0] pos_quot   = pos_prod / $signed({33'h0, num_r});
	wire logic signed [31:0] conv_pos   = pos_quot[31:0];
	wire logic signed [31:0] actual_pos = conv_pos + home_shift_r + offset_r;
	wire logic [31:0]        rev_prod   = {16'h0, den_r} * {16'h0, ppc_pkg::INC_PER_REV};
	wire logic [31:0]        rev_user   = rev_prod / {16'h0, num_r};
	wire logic [31:0]        win_max    = (rev_user * ppc_pkg::WINDOW_BASE) / {16'h0, ppc_pkg::INC_PER_REV};
	wire logic signed [31:0] hi_min     = map_end_r - $signed(rev_user * ppc_pkg::LIM_REV_FAR);
	wire logic signed [31:0] hi_max     = map_end_r - $signed(rev_user * ppc_pkg::LIM_REV_NEAR);

	// Request decode
	wire logic        q_wr     = q_valid_r & q_r.wr;
	wire logic [31:0] wd       = q_r.wdata;
	wire logic [15:0] wd16     = q_r.wdata[15:0];
	wire logic        still    = ~axis_moving;
	wire logic        hit_scr  = q_r.index == ppc_pkg::IDX_SCRATCH;
	wire logic        scr_cnt  = hit_scr & (q_r.sub == 8'h00);
	wire logic        scr_word = hit_scr & (q_r.sub != 8'h00) & (q_r.sub <= ppc_pkg::SCRATCH_COUNT);
	wire logic        hit_goal = q_r.index == ppc_pkg::IDX_GOAL;
	wire logic        hit_act  = q_r.index == ppc_pkg::IDX_ACTUAL;
	wire logic        hit_off  = q_r.index == ppc_pkg::IDX_OFFSET;
	wire logic        hit_ferr = q_r.index == ppc_pkg::IDX_FERR;
	wire logic        hit_win  = q_r.index == ppc_pkg::IDX_WINDOW;
	wire logic        hit_num  = q_r.index == ppc_pkg::IDX_NUM;
	wire logic        hit_den  = q_r.index == ppc_pkg::IDX_DEN;
	wire logic        hit_spda = q_r.index == ppc_pkg::IDX_SPD_AUTO;
	wire logic        hit_spdj = q_r.index == ppc_pkg::IDX_SPD_JOG;
	wire logic        hit_trqr = q_r.index == ppc_pkg::IDX_TRQ_RUN;
	wire logic        hit_hi   = q_r.index == ppc_pkg::IDX_LIM_HIGH;
	wire logic        hit_lo   = q_r.index == ppc_pkg::IDX_LIM_LOW;
	wire logic        hit_trqs = q_r.index == ppc_pkg::IDX_TRQ_START;
	wire logic        hit_sms  = q_r.index == ppc_pkg::IDX_START_MS;
	wire logic        hit_map  = q_r.index == ppc_pkg::IDX_MAP_END;
	wire logic        sub_zero = q_r.sub == 8'h00;
	wire logic        mapped   = (scr_cnt | scr_word) |
		(sub_zero & (hit_goal | hit_act | hit_off | hit_ferr | hit_win | hit_num | hit_den |
		hit_spda | hit_spdj | hit_trqr | hit_hi | hit_lo | hit_trqs | hit_sms | hit_map));

	// Writes refused unless at standstill
	wire logic        gated    = hit_act | hit_off | hit_win | hit_num | hit_den | hit_hi | hit_lo | hit_map;

	// Range checks per entry
	wire logic goal_ok  = ($signed(wd) <= lim_high_r) & ($signed(wd) >= lim_low_r);
	wire logic win_ok   = (wd16 >= ppc_pkg::WINDOW_MIN) & ({16'h0, wd16} <= win_max);
	wire logic scale_ok = (wd16 >= ppc_pkg::SCALE_MIN) & (wd16 <= ppc_pkg::SCALE_MAX);
	wire logic ferr_ok  = wd16 <= ppc_pkg::FERR_MAX;
	wire logic hi_ok    = ($signed(wd) >= hi_min) & ($signed(wd) <= hi_max);
	wire logic range_ok = (~hit_goal | goal_ok) & (~hit_win | win_ok) & (~(hit_num | hit_den) | scale_ok) &
		(~hit_ferr | ferr_ok) & (~hit_hi | hi_ok);

	wire logic refuse   = ~mapped | (q_r.wr & scr_cnt) | (q_r.wr & gated & ~still) | (q_r.wr & ~range_ok);
	wire logic wr_ok    = q_wr & ~refuse;

	// Goal write outcome
	wire logic goal_take = wr_ok & hit_goal;
	wire logic goal_rej  = q_wr & hit_goal & sub_zero & ~goal_ok;

	// Supervision
	wire logic signed [31:0] pos_diff  = goal_r - actual_pos;
	wire logic [31:0]        pos_abs   = pos_diff[31] ? 32'(-pos_diff) : pos_diff;
	wire logic               reached   = pos_abs <= {16'h0, window_r};
	wire logic [31:0]        ferr_abs  = follow_error[31] ? 32'(-follow_error) : follow_error;
	wire logic               drag      = ferr_abs > {16'h0, ferr_max_r};
	wire logic               pos_limit = actual_pos >= lim_high_r;
	wire logic               neg_limit = actual_pos <= lim_low_r;

	// Read selection, 16-bit entries zero-filled
	wire logic [31:0] rd_word =
		scr_cnt  ? {24'h0, ppc_pkg::SCRATCH_COUNT} :
		scr_word ? scratch_rdata :
		hit_goal ? goal_r :
		hit_act  ? actual_pos :
		hit_off  ? offset_r :
		hit_ferr ? {16'h0, ferr_max_r} :
		hit_win  ? {16'h0, window_r} :
		hit_num  ? {16'h0, num_r} :
		hit_den  ? {16'h0, den_r} :
		hit_spda ? {16'h0, spd_auto_r} :
		hit_spdj ? {16'h0, spd_jog_r} :
		hit_trqr ? {16'h0, trq_run_r} :
		hit_hi   ? lim_high_r :
		hit_lo   ? lim_low_r :
		hit_trqs ? {16'h0, trq_start_r} :
		hit_sms  ? {16'h0, start_ms_r} :
		hit_map  ? map_end_r : 32'h00000000;

	wire logic [31:0] rd_data = (q_valid_r & ~q_r.wr & ~refuse) ? rd_word : 32'h00000000;

	// Scratch store addressing, one-based sub index
	wire logic [7:0]                    req_sub_m1 = req.sub - 8'h01;
	wire logic [7:0]                    q_sub_m1   = q_r.sub - 8'h01;
	wire logic [ppc_pkg::SCRATCH_AW-1:0] scr_raddr  = req_sub_m1[ppc_pkg::SCRATCH_AW-1:0];
	wire logic [ppc_pkg::SCRATCH_AW-1:0] scr_waddr  = q_sub_m1[ppc_pkg::SCRATCH_AW-1:0];
	wire logic                          scr_we     = wr_ok & scr_word;

	// Start phase timing
	wire logic ms_tick   = prescale_r == 32'(CYC_PER_MS - 1);
	wire logic start_end = ms_tick & (ms_cnt_r + 16'h0001 >= start_ms_r);

	ppc_scratch_mem u_scratch (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.we      (scr_we),
		.waddr   (scr_waddr),
		.wdata   (wd),
		.raddr   (scr_raddr),
		.rdata_r (scratch_rdata)
	);

	// Request capture, read address already applied to the store
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q_valid_r <= 1'b0;
			q_r       <= '0;
			rsp_r     <= '0;
		end else begin
			q_valid_r     <= req_valid;
			q_r           <= req;
			rsp_r.ack     <= q_valid_r;
			rsp_r.refused <= q_valid_r & refuse;
			rsp_r.rdata   <= rd_data;
		end
	end

	// Position and referencing entries
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			goal_r       <= 32'h00000000;
			offset_r     <= 32'h00000000;
			home_shift_r <= 32'h00000000;
			lim_high_r   <= ppc_pkg::RST_LIM_HIGH;
			lim_low_r    <= ppc_pkg::RST_LIM_LOW;
			map_end_r    <= ppc_pkg::RST_MAP_END;
		end else begin
			if (goal_take) begin
				goal_r <= wd;
			end
			if (wr_ok & hit_off) begin
				offset_r <= wd;
			end
			if (wr_ok & hit_act) begin
				home_shift_r <= wd - conv_pos - offset_r;
			end
			if (wr_ok & hit_hi) begin
				lim_high_r <= wd;
			end
			if (wr_ok & hit_lo) begin
				lim_low_r <= wd;
			end
			if (wr_ok & hit_map) begin
				map_end_r <= wd;
			end
		end
	end

	// 16-bit tuning entries
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ferr_max_r  <= ppc_pkg::RST_FERR;
			window_r    <= ppc_pkg::RST_WINDOW;
			num_r       <= ppc_pkg::RST_SCALE;
			den_r       <= ppc_pkg::RST_SCALE;
			spd_auto_r  <= ppc_pkg::RST_SPD_AUTO;
			spd_jog_r   <= ppc_pkg::RST_SPD_JOG;
			trq_run_r   <= ppc_pkg::RST_TRQ_RUN;
			trq_start_r <= ppc_pkg::RST_TRQ_START;
			start_ms_r  <= ppc_pkg::RST_START_MS;
		end else begin
			if (wr_ok & hit_ferr) ferr_max_r <= wd16;
			if (wr_ok & hit_win) window_r <= wd16;
			if (wr_ok & hit_num) num_r <= wd16;
			if (wr_ok & hit_den) den_r <= wd16;
			if (wr_ok & hit_spda) spd_auto_r <= wd16;
			if (wr_ok & hit_spdj) spd_jog_r <= wd16;
			if (wr_ok & hit_trqr) trq_run_r <= wd16;
			if (wr_ok & hit_trqs) trq_start_r <= wd16;
			if (wr_ok & hit_sms) start_ms_r <= wd16;
		end
	end

	// Start phase: restarts on every move start, zero period skips it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_start_r <= 1'b0;
			prescale_r <= 32'h00000000;
			ms_cnt_r   <= 16'h0000;
		end else if (move_start) begin
			in_start_r <= start_ms_r != 16'h0000;
			prescale_r <= 32'h00000000;
			ms_cnt_r   <= 16'h0000;
		end else if (in_start_r) begin
			prescale_r <= ms_tick ? 32'h00000000 : prescale_r + 32'h00000001;
			ms_cnt_r   <= ms_tick ? ms_cnt_r + 16'h0001 : ms_cnt_r;
			in_start_r <= ~start_end;
		end
	end

	// Outputs to the motion core and status word
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_target_r <= 32'h00000000;
			target_go_r    <= 1'b0;
			speed_limit_r  <= ppc_pkg::RST_SPD_AUTO;
			torque_limit_r <= ppc_pkg::RST_TRQ_START;
			status_word_r  <= 16'h0000;
			bad_target_r   <= 1'b0;
		end else begin
			drive_target_r <= goal_r - offset_r - home_shift_r;
			target_go_r    <= goal_take;
			speed_limit_r  <= jog_active ? spd_jog_r : spd_auto_r;
			torque_limit_r <= in_start_r ? trq_start_r : trq_run_r;
			// Set wins over clear
			bad_target_r   <= goal_rej | (bad_target_r & ~goal_take);
			status_word_r  <= 16'h0000;
			status_word_r[ppc_pkg::ST_REACHED]    <= reached & still;
			status_word_r[ppc_pkg::ST_DRAG]       <= drag & axis_moving;
			status_word_r[ppc_pkg::ST_BAD_TARGET] <= goal_rej | (bad_target_r & ~goal_take);
			status_word_r[ppc_pkg::ST_POS_LIMIT]  <= pos_limit;
			status_word_r[ppc_pkg::ST_NEG_LIMIT]  <= neg_limit;
		end
	end
endmodule

/* verilog/ppc_scratch_mem.sv */
/*
 * Ten-word retained scratch store with registered read data.
 * Assumes the caller keeps addresses inside the ten words.
 */
`timescale 1ns/10ps
module ppc_scratch_mem (
	input  wire logic                               sys_clk,
	input  wire logic                               reset_n,
	input  wire logic                               we,
	input  wire logic [ppc_pkg::SCRATCH_AW-1:0]     waddr,
	input  wire logic [31:0]                        wdata,
	input  wire logic [ppc_pkg::SCRATCH_AW-1:0]     raddr,
	output logic      [31:0]                        rdata_r
);
	logic [31:0] mem_r [0:9];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 10; i++) begin
				mem_r[i] <= 32'h00000000;
			end
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= mem_r[raddr];
		end
	end
endmodule
